// >>> bridge_hdr_defs.svh
// Offsets, field positions and reset values of the bridge header bank.
// Assumes a 32-bit APB slave: each register is one word at 4 x index.
`ifndef BRIDGE_HDR_DEFS_SVH
`define BRIDGE_HDR_DEFS_SVH

// Register indices; byte address is four times the index
`define IDX_CLASS_CODE 10'h009
`define IDX_CACHE_LINE_SIZE 10'h00C
`define IDX_PRIMARY_LAT 10'h00D
`define IDX_HEADER_TYPE 10'h00E
`define IDX_SELF_TEST 10'h00F
`define IDX_UNUSED_WIN0 10'h010
`define IDX_UNUSED_WIN1 10'h014
`define IDX_UPSTREAM_BUS 10'h018
`define IDX_DOWNSTREAM_BUS 10'h019
`define IDX_HIGHEST_BUS 10'h01A
`define IDX_SECONDARY_LAT 10'h01B
`define IDX_IO_WINDOW_LOW 10'h01C
`define IDX_IO_WINDOW_HIGH 10'h01D
`define IDX_CAP_LOCK 10'h040

// Fixed read values
`define VAL_PROG_IF 8'h00
`define VAL_SUB_CLASS 8'h04
`define VAL_BASE_CLASS 8'h06
`define VAL_HEADER_TYPE 8'h01
`define VAL_SELF_TEST 8'h00
`define VAL_LATENCY 8'h00
`define VAL_UNUSED_WIN 32'h0000_0000

// Reset values
`define RST_CACHE_LINE 8'h00
`define RST_BUS_NUMBER 8'h00
`define RST_IO_CAP 1'b1
`define RST_IO_LOW 4'hF
`define RST_IO_HIGH 4'h0
`define RST_CAP_LOCK 1'b0

// Field positions and window fill patterns
`define FLD_IO_CAP 0
`define FLD_NIBBLE_HI 7
`define FLD_NIBBLE_LO 4
`define IO_LOW_FILL 12'h000
`define IO_HIGH_FILL 12'hFFF
`define NUM_BUS_REGS 3

`endif

// >>> bridge_hdr_pkg.sv
// Types used by the bridge header bank; its window comparator uses none of them.
// Assumes bridge_hdr_defs.svh is on the include path.
`default_nettype none

package bridge_hdr_pkg;
    typedef logic [9:0] reg_index_t;
    typedef logic [7:0] byte_t;

    // All state of the register bank, registered as one word
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        byte_t cache_line_size;
        byte_t [2:0] bus_number;
        logic io_width_capability;
        logic [3:0] io_window_low;
        logic [3:0] io_window_high;
        logic cap_lock;
        logic in_window;
        logic forward;
    } bridge_state_s;
endpackage

`default_nettype wire

// >>> io_window_match.sv
// Inclusive I/O window compare from the base and limit nibbles.
// Assumes address comes from logic on the same clock; purely combinational.
`default_nettype none
`include "bridge_hdr_defs.svh"

module io_window_match (
    input wire logic [3:0] io_window_low,
    input wire logic [3:0] io_window_high,
    input wire logic [31:0] addr,
    output logic hit
);
    logic [15:0] lower;
    logic [15:0] upper;

    assign lower = {io_window_low, `IO_LOW_FILL};
    assign upper = {io_window_high, `IO_HIGH_FILL};

    // inclusive range check
    // Upper address half lives outside this bank, so it must be zero here
    assign hit = (addr[31:16] == 16'h0000) && (addr[15:0] >= lower)
        && (addr[15:0] <= upper);
endmodule

`default_nettype wire

// >>> bridge_type1_header_regs.sv
// Type 1 bridge header bank, indices 0x009 to 0x01D, behind an APB slave.
// Assumes one clock; the I/O request comes from logic on that clock.
//
// Our own choice: the APB register port.
`default_nettype none
`include "bridge_hdr_defs.svh"

// Functional notes
// - class code fixed, bridge-to-bridge, no subtractive
// - cache line size read/write, no effect
// - header type fixed, type 1 single function
// - self-test byte reads zero
// - both unused windows read zero
// - both latency timers read zero
// - upstream bus number read/write, no effect
// - downstream and highest bus numbers read/write
// - width capability bit, lockable, resets one
// - limit bit 0 mirrors capability bit
// - base nibble read/write, resets all ones
// - limit nibble read/write, resets zero
// - window governs which I/O is forwarded
module bridge_type1_header_regs (
    input wire logic clock,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic io_req_valid,
    input wire logic [31:0] io_req_addr,
    output logic io_in_window,
    output logic io_forward,
    output logic [7:0] downstream_bus_number,
    output logic [7:0] highest_bus_number,
    output logic io_width_capability
);
    // How the bank behaves on the bus:
    // - every transfer is answered in its first access cycle, no waits
    // - read data and the error flag are taken at setup, so both are
    //   flop outputs in the access cycle and zero outside it
    // - an unmapped or misaligned word gives an error and reads zero
    // - writes to fixed words, or without lane 0, vanish silently
    // - the lock word freezes only the I/O width bit, nothing else
    // - two bus numbers leave the bank for routing; the upstream one
    //   stays inside, since nothing here depends on it
    // The window verdict is registered: it appears one cycle after the
    // request, and the in-window level holds until the next request.
    // Decode helpers, the state register pair and the read path
    bridge_hdr_pkg::bridge_state_s s_q;
    bridge_hdr_pkg::bridge_state_s s_d;
    logic window_hit;
    logic setup_phase;
    logic access_done;
    bridge_hdr_pkg::reg_index_t idx;
    logic aligned;
    logic [31:0] read_word;
    logic read_hit;
    logic write_commit;

    // Maps a byte address to a register index
    // Bits 1:0 are dropped here; alignment is judged on its own, so a
    // misaligned word still decodes but is refused with an error
    function automatic bridge_hdr_pkg::reg_index_t to_index(
        input logic [11:0] a
    );
        to_index = a[11:2];
    endfunction

    // True when the index names a register of this bank
    // The lock word is ours and sits well clear of the header words
    // A new register needs its index here and in both case statements
    function automatic logic is_mapped(
        input bridge_hdr_pkg::reg_index_t i
    );
        case (i)
            `IDX_CLASS_CODE,
            `IDX_CACHE_LINE_SIZE,
            `IDX_PRIMARY_LAT,
            `IDX_HEADER_TYPE,
            `IDX_SELF_TEST,
            `IDX_UNUSED_WIN0,
            `IDX_UNUSED_WIN1,
            `IDX_UPSTREAM_BUS,
            `IDX_DOWNSTREAM_BUS,
            `IDX_HIGHEST_BUS,
            `IDX_SECONDARY_LAT,
            `IDX_IO_WINDOW_LOW,
            `IDX_IO_WINDOW_HIGH,
            `IDX_CAP_LOCK: begin
                is_mapped = 1'b1;
            end
            default: begin
                is_mapped = 1'b0;
            end
        endcase
    endfunction

    // True when the index is one of the three bus number bytes
    // The three bytes sit at consecutive indices, so a range will do
    function automatic logic is_bus_reg(
        input bridge_hdr_pkg::reg_index_t i
    );
        is_bus_reg = (i >= `IDX_UPSTREAM_BUS) && (i <= `IDX_HIGHEST_BUS);
    endfunction

    // Compare lives in its own module so forwarding logic can reuse it
    // It sees only the two nibbles: the width bit does not widen the
    // window, since the upper I/O address half lives outside this bank
    // The verdict is registered in the state word, not in there
    io_window_match u_window (
        .io_window_low(s_q.io_window_low),
        .io_window_high(s_q.io_window_high),
        .addr(io_req_addr),
        .hit(window_hit)
    );

    // Bus phase decode
    // The bank answers in the first access cycle, so access_done marks
    // the one edge at which a write may take effect
    assign setup_phase = psel && !penable;
    assign access_done = psel && penable && s_q.pready;
    assign idx = to_index(paddr);
    assign aligned = (paddr[1:0] == 2'b00);
    // Only the low lane carries data for byte registers
    assign write_commit = access_done && pwrite && read_hit && pstrb[0];

    // Read multiplexer, upper bits of byte registers read zero
    // Each byte register sits alone in bits 7:0 of its word, so
    // software never has to mask neighbouring fields
    always_comb begin
        read_word = 32'h0000_0000;
        read_hit = aligned && is_mapped(idx);
        case (idx)
            `IDX_CLASS_CODE: begin
                // Base class, sub class, interface, high to low
                read_word[23:0] = {`VAL_BASE_CLASS, `VAL_SUB_CLASS,
                    `VAL_PROG_IF};
            end
            `IDX_CACHE_LINE_SIZE: begin
                read_word[7:0] = s_q.cache_line_size;
            end
            `IDX_PRIMARY_LAT: begin
                read_word[7:0] = `VAL_LATENCY;
            end
            `IDX_HEADER_TYPE: begin
                read_word[7:0] = `VAL_HEADER_TYPE;
            end
            `IDX_SELF_TEST: begin
                read_word[7:0] = `VAL_SELF_TEST;
            end
            `IDX_UNUSED_WIN0: begin
                read_word = `VAL_UNUSED_WIN;
            end
            `IDX_UNUSED_WIN1: begin
                read_word = `VAL_UNUSED_WIN;
            end
            `IDX_UPSTREAM_BUS: begin
                read_word[7:0] = s_q.bus_number[0];
            end
            `IDX_DOWNSTREAM_BUS: begin
                read_word[7:0] = s_q.bus_number[1];
            end
            // Highest bus number sits in slot two
            `IDX_HIGHEST_BUS: begin
                read_word[7:0] = s_q.bus_number[2];
            end
            `IDX_SECONDARY_LAT: begin
                read_word[7:0] = `VAL_LATENCY;
            end
            // bits 3 to 1 stay zero
            `IDX_IO_WINDOW_LOW: begin
                read_word[`FLD_NIBBLE_HI:`FLD_NIBBLE_LO] =
                    s_q.io_window_low;
                read_word[`FLD_IO_CAP] = s_q.io_width_capability;
            end
            `IDX_IO_WINDOW_HIGH: begin
                read_word[`FLD_NIBBLE_HI:`FLD_NIBBLE_LO] =
                    s_q.io_window_high;
                read_word[`FLD_IO_CAP] = s_q.io_width_capability;
            end
            // Lock word reads back in bit 0
            `IDX_CAP_LOCK: begin
                read_word[0] = s_q.cap_lock;
            end
            // Unmapped index, refused through read_hit as well
            default: begin
                read_word = 32'h0000_0000;
            end
        endcase
        // Misaligned or unmapped access reads back zero
        // so a refused read can never leak a neighbouring register
        if (!read_hit) begin
            read_word = 32'h0000_0000;
        end
    end

    // Next state of the whole bank
    always_comb begin
        // Everything holds unless a branch below moves it
        s_d = s_q;

        // Ready one cycle after setup: every access has one wait-free
        // access phase, so the master never stalls more than that
        // A transfer therefore takes exactly two cycles on the bus
        s_d.pready = setup_phase;

        // Read data and error are captured at setup and held in access
        // Capture at setup keeps prdata a flop output with no wait state;
        // a write just before has landed by then, so nothing reads stale
        if (setup_phase) begin
            s_d.prdata = pwrite ? 32'h0000_0000 : read_word;
            s_d.pslverr = !read_hit;
        end else if (access_done) begin
            s_d.prdata = 32'h0000_0000;
            s_d.pslverr = 1'b0;
        end

        // Writes land only at the completing edge, low lane only;
        // read-only bytes silently ignore writes without an error
        // A strobe without lane 0 is dropped whole, never merged
        if (write_commit) begin
            case (idx)
                `IDX_CACHE_LINE_SIZE: begin
                    s_d.cache_line_size = pwdata[7:0];
                end
                // bits 3 to 1 not stored
                `IDX_IO_WINDOW_LOW: begin
                    s_d.io_window_low =
                        pwdata[`FLD_NIBBLE_HI:`FLD_NIBBLE_LO];
                    // Bits 3 to 1 of the written byte are dropped
                    // capability write unless locked
                    if (!s_q.cap_lock) begin
                        s_d.io_width_capability = pwdata[`FLD_IO_CAP];
                    end
                end
                // limit nibble write, bit 0 ignored
                `IDX_IO_WINDOW_HIGH: begin
                    // Bit 0 is a mirror, so its written value is dropped
                    s_d.io_window_high =
                        pwdata[`FLD_NIBBLE_HI:`FLD_NIBBLE_LO];
                end
                // Lock guards the capability bit against stray writes
                // Writing one freezes the width bit until written zero
                `IDX_CAP_LOCK: begin
                    s_d.cap_lock = pwdata[0];
                end
                // Fixed words drop the data; no error is raised
                `IDX_CLASS_CODE, `IDX_HEADER_TYPE, `IDX_SELF_TEST,
                `IDX_PRIMARY_LAT, `IDX_SECONDARY_LAT, `IDX_UNUSED_WIN0,
                `IDX_UNUSED_WIN1: begin
                end
                // Bus numbers are stored by the loop below
                default: begin
                end
            endcase

            // upstream, downstream and highest stored
            // One slot per byte keeps the three writes identical
            for (int b = 0; b < `NUM_BUS_REGS; b++) begin
                if (is_bus_reg(idx) &&
                    (idx - `IDX_UPSTREAM_BUS) == 10'(b)) begin
                    s_d.bus_number[b] = pwdata[7:0];
                end
            end
        end

        // in_window keeps the last verdict; forward is a one-cycle pulse
        // that the forwarding logic may take as a grant, and cycles
        // without a request leave the verdict alone
        // window steers forwarding
        if (io_req_valid) begin
            s_d.in_window = window_hit;
        end
        s_d.forward = io_req_valid && window_hit;
    end

    // Single state register; reset loads constants only
    // A reset in mid-run also opens the lock, so boot code may choose
    // the I/O width again before it sets up the window
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            // Bus handshake and read path start idle
            s_q.pready <= 1'b0;
            s_q.pslverr <= 1'b0;
            s_q.prdata <= 32'h0000_0000;
            s_q.cache_line_size <= `RST_CACHE_LINE;
            s_q.bus_number <= {`NUM_BUS_REGS{`RST_BUS_NUMBER}};
            s_q.io_width_capability <= `RST_IO_CAP;
            // Window starts empty, base above limit
            // base nibble resets all ones
            s_q.io_window_low <= `RST_IO_LOW;
            s_q.io_window_high <= `RST_IO_HIGH;
            // Lock starts open
            s_q.cap_lock <= `RST_CAP_LOCK;
            // No request seen yet, so no verdict and no forward
            s_q.in_window <= 1'b0;
            s_q.forward <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    // The upstream number stays inside: nothing downstream uses it
    // Every port is a flop output, so no port sees a decode glitch
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign io_in_window = s_q.in_window;
    assign io_forward = s_q.forward;
    assign downstream_bus_number = s_q.bus_number[1];
    assign highest_bus_number = s_q.bus_number[2];
    assign io_width_capability = s_q.io_width_capability;
endmodule

`default_nettype wire

// >>> bridge_type1_header_regs_chk.sv
// Assertions on the ports of the bridge header bank.
// Assumes APB answers in one access cycle, as the bank's note states.
`default_nettype none
module bridge_type1_header_regs_chk (
    input wire logic clock,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic io_req_valid,
    input wire logic [31:0] io_req_addr,
    input wire logic io_in_window,
    input wire logic io_forward,
    input wire logic [7:0] downstream_bus_number,
    input wire logic [7:0] highest_bus_number,
    input wire logic io_width_capability
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    logic rd, wr;
    // Completed read and byte-0 write cycles
    assign rd = pready && !pwrite;
    assign wr = psel && penable && pready && pwrite && pstrb[0];

    chk_class_value: assert property (rd && paddr == 12'h024 |->
        prdata == 32'h0006_0400) else $error("class code read wrong");
    chk_header_value: assert property (rd && paddr == 12'h038 |->
        prdata == 32'h0000_0001) else $error("header type read wrong");
    chk_zero_regs: assert property (rd &&
        paddr inside {12'h034, 12'h03C, 12'h040, 12'h050, 12'h06C}
        |-> prdata == 32'h0) else $error("fixed zero read wrong");
    chk_bus_reset: assert property ($fell(reset) |->
        downstream_bus_number == 8'h00 && highest_bus_number == 8'h00)
        else $error("bus numbers not zero after reset");
    chk_cap_reset: assert property ($fell(reset) |->
        io_width_capability) else $error("capability not one after reset");
    chk_down_write: assert property (wr && paddr == 12'h064 |=>
        downstream_bus_number == $past(pwdata[7:0]))
        else $error("downstream bus write lost");
    chk_bus_hold: assert property (!wr |=>
        $stable(downstream_bus_number) && $stable(highest_bus_number))
        else $error("bus number moved without a write");
    chk_cap_hold: assert property (!wr |=>
        $stable(io_width_capability)) else $error("capability moved");
    chk_fwd_window: assert property (io_req_valid |=>
        io_forward == io_in_window) else $error("forward disagrees");
    chk_upper_miss: assert property (io_req_valid &&
        io_req_addr[31:16] != 16'h0 |=> !io_in_window && !io_forward)
        else $error("upper address bits gave a hit");
    chk_window_hold: assert property (!io_req_valid |=>
        $stable(io_in_window) && !io_forward)
        else $error("window result moved without request");

    cover property (wr && paddr == 12'h070);
    cover property (io_forward);
    cover property (rd && paddr == 12'h024);
endmodule

bind bridge_type1_header_regs bridge_type1_header_regs_chk
    bridge_type1_header_regs_chk_inst (.clock(clock), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .io_req_valid(io_req_valid), .io_req_addr(io_req_addr),
    .io_in_window(io_in_window), .io_forward(io_forward),
    .downstream_bus_number(downstream_bus_number),
    .highest_bus_number(highest_bus_number),
    .io_width_capability(io_width_capability));
`default_nettype wire

// >>> bridge_type1_header_regs_test.sv
// Self-checking bench for the bridge header bank over APB.
// Assumes one 200 MHz clock and an active-high asynchronous reset.
`default_nettype none
module bridge_type1_header_regs_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0, reset = 1'b1, io_req_valid = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, io_req_addr = 32'h0, prdata;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, io_in_window, io_forward, io_width_capability;
    logic [7:0] downstream_bus_number, highest_bus_number;
    int err_total = 0, compares = 0, cycles = 0;

    bridge_type1_header_regs bridge_type1_header_regs_inst (
        .clock(clock), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .io_req_valid(io_req_valid), .io_req_addr(io_req_addr),
        .io_in_window(io_in_window), .io_forward(io_forward),
        .downstream_bus_number(downstream_bus_number),
        .highest_bus_number(highest_bus_number),
        .io_width_capability(io_width_capability));

    // Clock, 5 ns period
    initial begin
        forever #2.5 clock = ~clock;
    end

    // Hang guard, far above the roughly 160 cycles needed
    always @(posedge clock) begin
        cycles++;
        if (cycles >= 4000) begin
            err_total++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d, output logic [31:0] v, output logic e);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        v = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] v;
        logic e;
        apb(1'b1, a, d, v, e);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp,
            input logic ee = 1'b0);
        logic [31:0] v;
        logic e;
        apb(1'b0, a, 32'h0, v, e);
        check($sformatf("read %h", a), v, exp);
        check($sformatf("error %h", a), {31'h0, e}, {31'h0, ee});
    endtask

    // Request one cycle, look once its result has landed
    task automatic io_req(input logic [31:0] a, input logic hit);
        @(posedge clock);
        io_req_valid <= 1'b1;
        io_req_addr <= a;
        @(posedge clock);
        io_req_valid <= 1'b0;
        io_req_addr <= ~a;
        #1;
        check("in window", {31'h0, io_in_window}, {31'h0, hit});
        check("forward", {31'h0, io_forward}, {31'h0, hit});
    endtask

    task automatic t_reset_values();
        rdc(12'h070, 32'hF1);
        rdc(12'h074, 32'h01);
        rdc(12'h030, 32'h0);
        rdc(12'h060, 32'h0);
        rdc(12'h068, 32'h0);
        io_req(32'h0000_F000, 1'b0);
    endtask

    // Read-only places ignore writes of all ones
    task automatic t_read_only();
        logic [11:0] ad [7] = '{12'h024, 12'h034, 12'h038, 12'h03C,
            12'h040, 12'h050, 12'h06C};
        logic [31:0] ex [7] = '{32'h0006_0400, 32'h0, 32'h1, 32'h0,
            32'h0, 32'h0, 32'h0};
        for (int i = 0; i < 7; i++) begin
            wr(ad[i], 32'hFFFF_FFFF);
            rdc(ad[i], ex[i]);
        end
    endtask

    task automatic t_bus_numbers();
        wr(12'h064, 32'hFFFF_FF12);
        wr(12'h068, 32'h0000_0034);
        wr(12'h060, 32'h0000_003C);
        wr(12'h030, 32'h0000_00A5);
        rdc(12'h060, 32'h3C);
        rdc(12'h030, 32'hA5);
        rdc(12'h064, 32'h12);
        rdc(12'h068, 32'h34);
        check("downstream", downstream_bus_number, 8'h12);
        check("highest", highest_bus_number, 8'h34);
    endtask

    task automatic t_io_window();
        logic [31:0] ad [6] = '{32'h4FFF, 32'h5000, 32'h6ABC, 32'h7FFF,
            32'h8000, 32'h0001_5000};
        logic [5:0] hit = 6'b011100;
        wr(12'h070, 32'h0000_005E);
        wr(12'h074, 32'h0000_007F);
        rdc(12'h070, 32'h50);
        rdc(12'h074, 32'h70);
        check("capability", io_width_capability, 32'h0);
        for (int i = 0; i < 6; i++) begin
            io_req(ad[i], hit[5 - i]);
        end
    endtask

    // Locked capability, then unmapped and misaligned places
    task automatic t_lock_and_errors();
        wr(12'h100, 32'h1);
        rdc(12'h100, 32'h1);
        wr(12'h070, 32'h51);
        rdc(12'h070, 32'h50);
        wr(12'h100, 32'h0);
        wr(12'h070, 32'h51);
        rdc(12'h074, 32'h71);
        check("capability", io_width_capability, 32'h1);
        rdc(12'h0FC, 32'h0, 1'b1);
        rdc(12'h025, 32'h0, 1'b1);
    endtask

    initial begin
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        t_reset_values();
        t_read_only();
        t_bus_numbers();
        t_io_window();
        t_lock_and_errors();
        // Second reset in mid-run must undo every write made so far
        @(posedge clock);
        reset <= 1'b1;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        t_reset_values();
        complete_run();
    end
endmodule
`default_nettype wire
